/* File: hw/pump_consts.svh */
// Constants for the syringe plunger and valve sequencer
`ifndef PUMP_CONSTS_SVH
`define PUMP_CONSTS_SVH
`define CLK_HZ 40000000
`define SLOPE_TICK_US 400
`define POS_MAX 3000
`define MICRO_HZ 1024
`define INIT_HZ 500
`define SLOPE_DEF 14
`define SLOPE_MIN 1
`define SLOPE_MAX 20
`define TOP_DEF 1400
`define TOP_MIN 5
`define TOP_MAX 5800
`define START_DEF 900
`define START_MIN 50
`define START_MAX 1000
`define CUT_DEF 900
`define CUT_MIN 50
`define CUT_MAX 2700
`define BL_DEF 0
`define BL_MAX 31
`define THRESH_DEF 0
`define OTF_MIN 5
`define OTF_MAX 1024
`define ERR_OPERAND 4'h3
`define ERR_BUSY 4'h7
`define ERR_BYPASS 4'hB
`endif

/* File: hw/pump_pkg.sv */
// Types shared by the syringe plunger and valve sequencer
package pump_pkg;
    typedef enum logic [4:0] {
        OP_INIT_RIGHT, OP_INIT_LEFT, OP_INIT_NOVALVE, OP_RESYNC,
        OP_ABS, OP_PICKUP, OP_DISPENSE,
        OP_VALVE_IN, OP_VALVE_OUT, OP_VALVE_BYPASS, OP_VALVE_EXTRA,
        OP_SET_THRESH, OP_SET_SLOPE, OP_SET_TOP, OP_SET_START, OP_SET_CUTOFF,
        OP_SET_BACKLASH
    } op_t;
    typedef struct packed {
        op_t op;
        logic quiet;
        logic [15:0] arg;
    } cmd_t;
    typedef enum logic [2:0] {
        PORT_NONE, PORT_LEFT, PORT_RIGHT, PORT_BYPASS, PORT_EXTRA
    } port_t;
    typedef enum logic [2:0] {
        S_IDLE = 3'h0, S_RUN = 3'h1, S_BACK = 3'h3, S_HOME = 3'h2, S_VALVE = 3'h6
    } state_t;
    typedef struct packed {
        state_t state;
        logic [11:0] pos;
        logic [11:0] rem;
        logic [11:0] up;
        logic [12:0] vel;
        logic [12:0] top;
        logic [12:0] start;
        logic [12:0] cut;
        logic [12:0] endv;
        logic [12:0] saved;
        logic [4:0] slope;
        logic [4:0] bl;
        logic [7:0] thresh;
        logic [25:0] acc;
        logic [23:0] tick;
        port_t valve;
        logic out_right;
        logic half;
        logic down;
        logic decel;
        logic bl_pend;
        logic quiet;
        logic otf;
        logic step;
        logic vgo;
        logic err_stb;
        logic [3:0] err;
    } st_t;
endpackage : pump_pkg

/* File: hw/syringe_plunger_valve_sequencer.sv */
// Command-driven plunger motion and valve sequencer
`timescale 1ns/1ps
`default_nettype none
`include "pump_consts.svh"
module syringe_plunger_valve_sequencer #(
    parameter int TICK_CYC = `SLOPE_TICK_US * (`CLK_HZ / 1000000)
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire pump_pkg::cmd_t cmd,
    output logic cmd_ready,
    input wire logic valve_fitted,
    input wire logic distrib_valve,
    input wire logic home_hit,
    input wire logic valve_done,
    input wire logic [11:0] encoder_pos,
    input wire logic [7:0] fluid_level,
    output logic busy,
    output logic err_strobe,
    output logic [3:0] err_code,
    output logic step_pulse,
    output logic step_down,
    output logic microstep,
    output logic half_force,
    output pump_pkg::port_t valve_target,
    output logic valve_go,
    output logic leak_alarm,
    output logic [11:0] plunger_pos
);
    pump_pkg::st_t st_q, st_d;
    logic fire, moving, is_move, is_valve;

    assign moving = st_q.state inside {pump_pkg::S_RUN, pump_pkg::S_BACK, pump_pkg::S_HOME};
    assign cmd_ready = (st_q.state == pump_pkg::S_IDLE) | (st_q.state == pump_pkg::S_RUN & st_q.quiet);
    assign fire = cmd_valid & cmd_ready;
    assign is_move = cmd.op inside {pump_pkg::OP_ABS, pump_pkg::OP_PICKUP, pump_pkg::OP_DISPENSE};
    assign is_valve = cmd.op inside {pump_pkg::OP_VALVE_IN, pump_pkg::OP_VALVE_OUT,
                                     pump_pkg::OP_VALVE_BYPASS, pump_pkg::OP_VALVE_EXTRA};

    always_comb
    begin
        logic [25:0] sum;
        logic [12:0] tgt;
        logic [12:0] inc;
        logic [12:0] nv;
        sum = st_q.acc + 26'(st_q.vel);
        tgt = 13'h0;
        inc = 13'(st_q.slope);
        nv = st_q.vel;
        st_d = st_q;
        st_d.step = 1'b0;
        st_d.vgo = 1'b0;
        st_d.err_stb = 1'b0;
        // Phase accumulator: one step each time the velocity sum passes the clock rate
        if (moving)
        begin
            if (sum >= 26'(`CLK_HZ))
            begin
                st_d.acc = sum - 26'(`CLK_HZ);
                st_d.step = 1'b1;
            end
            else
                st_d.acc = sum;
        end
        unique case (st_q.state)
            pump_pkg::S_IDLE, pump_pkg::S_VALVE:
            begin
                if (st_q.state == pump_pkg::S_VALVE && valve_done)
                    st_d.state = pump_pkg::S_IDLE;
            end
            pump_pkg::S_HOME:
            begin
                if (home_hit)
                begin
                    st_d.pos = 12'h0;
                    st_d.state = pump_pkg::S_IDLE;
                end
            end
            pump_pkg::S_RUN, pump_pkg::S_BACK:
            begin
                if (st_q.state == pump_pkg::S_BACK)
                    st_d.down = 1'b0;
                // Ramp on a fixed tick; a unit of slope code is 1 Hz per 400 us
                if (st_q.tick == 24'(TICK_CYC - 1))
                begin
                    st_d.tick = 24'h0;
                    if (!st_q.otf && st_q.state == pump_pkg::S_RUN)
                    begin
                        if (st_q.decel)
                            nv = (st_q.vel > st_q.endv + inc) ? st_q.vel - inc : st_q.endv;
                        else
                            nv = (st_q.vel + inc < st_q.top) ? st_q.vel + inc : st_q.top;
                        st_d.vel = nv;
                    end
                end
                else
                    st_d.tick = st_q.tick + 24'h1;
                if (st_d.step)
                begin
                    st_d.pos = st_q.down ? st_q.pos + 12'h1 : st_q.pos - 12'h1;
                    st_d.rem = st_q.rem - 12'h1;
                    // Accel steps counted, decel gets the same count, top takes the rest
                    if (!st_q.decel && st_q.vel < st_q.top)
                        st_d.up = st_q.up + 12'h1;
                    if (st_d.rem <= st_d.up)
                        st_d.decel = 1'b1;
                    if (st_q.rem == 12'h1)
                    begin
                        if (st_q.bl_pend)
                        begin
                            st_d.state = pump_pkg::S_BACK;
                            st_d.rem = 12'(st_q.bl);
                            st_d.bl_pend = 1'b0;
                            st_d.vel = st_q.start;
                        end
                        else
                        begin
                            st_d.state = pump_pkg::S_IDLE;
                            st_d.quiet = 1'b0;
                            st_d.otf = 1'b0;
                            if (st_q.otf)
                                st_d.top = st_q.saved;
                        end
                    end
                end
            end
        endcase
        if (fire && st_q.state == pump_pkg::S_RUN)
        begin
            // Only a top velocity change is taken while a quiet move runs
            if (cmd.op == pump_pkg::OP_SET_TOP && st_q.start == st_q.top
                && cmd.arg >= 16'(`OTF_MIN) && cmd.arg <= 16'(`OTF_MAX))
            begin
                if (!st_q.otf)
                    st_d.saved = st_q.top;
                st_d.otf = 1'b1;
                st_d.top = 13'(cmd.arg);
                st_d.vel = 13'(cmd.arg);
            end
            else
            begin
                st_d.err_stb = 1'b1;
                st_d.err = (cmd.op == pump_pkg::OP_SET_TOP) ? `ERR_OPERAND : `ERR_BUSY;
            end
        end
        else if (fire)
        begin
            unique case (cmd.op)
                pump_pkg::OP_INIT_RIGHT, pump_pkg::OP_INIT_LEFT, pump_pkg::OP_INIT_NOVALVE:
                begin
                    if (cmd.arg > 16'h1)
                    begin
                        st_d.err_stb = 1'b1;
                        st_d.err = `ERR_OPERAND;
                    end
                    else
                    begin
                        st_d.state = pump_pkg::S_HOME;
                        st_d.half = cmd.arg[0];
                        st_d.down = 1'b0;
                        st_d.acc = 26'h0;
                        st_d.vel = 13'(`INIT_HZ);
                        if (cmd.op != pump_pkg::OP_INIT_NOVALVE)
                            st_d.out_right = (cmd.op == pump_pkg::OP_INIT_RIGHT);
                        // Init restores every parameter except the leak threshold to its default
                        st_d.top = 13'(`TOP_DEF);
                        st_d.start = 13'(`START_DEF);
                        st_d.cut = 13'(`CUT_DEF);
                        st_d.slope = 5'(`SLOPE_DEF);
                        st_d.bl = 5'(`BL_DEF);
                    end
                end
                pump_pkg::OP_RESYNC:
                    if (distrib_valve)
                        st_d.pos = encoder_pos;
                pump_pkg::OP_ABS, pump_pkg::OP_PICKUP, pump_pkg::OP_DISPENSE:
                begin
                    if (cmd.op == pump_pkg::OP_ABS)
                        tgt = (cmd.arg > 16'(`POS_MAX)) ? 13'h1FFF : 13'(cmd.arg);
                    else if (cmd.op == pump_pkg::OP_PICKUP)
                        tgt = (cmd.arg > 16'(`POS_MAX)) ? 13'h1FFF : 13'(st_q.pos) + 13'(cmd.arg);
                    else
                        tgt = (cmd.arg > 16'(st_q.pos)) ? 13'h1FFF : 13'(st_q.pos) - 13'(cmd.arg);
                    if (st_q.valve == pump_pkg::PORT_BYPASS)
                    begin
                        st_d.err_stb = 1'b1;
                        st_d.err = `ERR_BYPASS;
                    end
                    else if (tgt > 13'(`POS_MAX))
                    begin
                        st_d.err_stb = 1'b1;
                        st_d.err = `ERR_OPERAND;
                    end
                    else if (tgt != 13'(st_q.pos))
                    begin
                        st_d.state = pump_pkg::S_RUN;
                        st_d.down = tgt > 13'(st_q.pos);
                        st_d.rem = st_d.down ? 12'(tgt) - st_q.pos + 12'(st_q.bl)
                                             : st_q.pos - 12'(tgt);
                        st_d.bl_pend = st_d.down && st_q.bl != 5'h0;
                        st_d.endv = st_d.down ? st_q.start : st_q.cut;
                        st_d.vel = st_q.start;
                        st_d.quiet = cmd.quiet;
                        st_d.up = 12'h0;
                        st_d.decel = 1'b0;
                        st_d.acc = 26'h0;
                        st_d.tick = 24'h0;
                    end
                end
                pump_pkg::OP_VALVE_IN, pump_pkg::OP_VALVE_OUT, pump_pkg::OP_VALVE_BYPASS,
                pump_pkg::OP_VALVE_EXTRA:
                begin
                    if (valve_fitted && (cmd.op != pump_pkg::OP_VALVE_EXTRA || distrib_valve))
                    begin
                        st_d.state = pump_pkg::S_VALVE;
                        st_d.vgo = 1'b1;
                        unique case (cmd.op)
                            pump_pkg::OP_VALVE_IN:
                                st_d.valve = st_q.out_right ? pump_pkg::PORT_LEFT
                                                            : pump_pkg::PORT_RIGHT;
                            pump_pkg::OP_VALVE_OUT:
                                st_d.valve = st_q.out_right ? pump_pkg::PORT_RIGHT
                                                            : pump_pkg::PORT_LEFT;
                            pump_pkg::OP_VALVE_BYPASS: st_d.valve = pump_pkg::PORT_BYPASS;
                            default: st_d.valve = pump_pkg::PORT_EXTRA;
                        endcase
                    end
                end
                default:
                begin
                    // Setters: an argument out of range leaves the setting untouched
                    unique case (cmd.op)
                        pump_pkg::OP_SET_THRESH:
                            st_d.err_stb = cmd.arg > 16'hFF;
                        pump_pkg::OP_SET_SLOPE:
                            st_d.err_stb = cmd.arg < 16'(`SLOPE_MIN) || cmd.arg > 16'(`SLOPE_MAX);
                        pump_pkg::OP_SET_TOP:
                            st_d.err_stb = cmd.arg < 16'(`TOP_MIN) || cmd.arg > 16'(`TOP_MAX);
                        pump_pkg::OP_SET_START:
                            st_d.err_stb = cmd.arg < 16'(`START_MIN) || cmd.arg > 16'(`START_MAX);
                        pump_pkg::OP_SET_CUTOFF:
                            st_d.err_stb = cmd.arg < 16'(`CUT_MIN) || cmd.arg > 16'(`CUT_MAX);
                        default:
                            st_d.err_stb = cmd.arg > 16'(`BL_MAX);
                    endcase
                    if (st_d.err_stb)
                        st_d.err = `ERR_OPERAND;
                    else
                        unique case (cmd.op)
                            pump_pkg::OP_SET_THRESH: st_d.thresh = cmd.arg[7:0];
                            pump_pkg::OP_SET_SLOPE: st_d.slope = cmd.arg[4:0];
                            pump_pkg::OP_SET_TOP: st_d.top = cmd.arg[12:0];
                            pump_pkg::OP_SET_START: st_d.start = cmd.arg[12:0];
                            pump_pkg::OP_SET_CUTOFF: st_d.cut = cmd.arg[12:0];
                            default: st_d.bl = cmd.arg[4:0];
                        endcase
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= '0;
            st_q.top <= 13'(`TOP_DEF);
            st_q.start <= 13'(`START_DEF);
            st_q.cut <= 13'(`CUT_DEF);
            st_q.slope <= 5'(`SLOPE_DEF);
            st_q.thresh <= 8'(`THRESH_DEF);
        end
        else
            st_q <= st_d;
    end

    assign busy = st_q.state != pump_pkg::S_IDLE && !st_q.quiet;
    assign err_strobe = st_q.err_stb;
    assign err_code = st_q.err;
    assign step_pulse = st_q.step;
    assign step_down = st_q.down;
    assign microstep = moving && st_q.vel < 13'(`MICRO_HZ);
    assign half_force = st_q.half && st_q.state == pump_pkg::S_HOME;
    assign valve_target = st_q.valve;
    assign valve_go = st_q.vgo;
    // Lower reading means wetter, so a higher threshold trips earlier
    assign leak_alarm = st_q.thresh != 8'h0 && fluid_level < st_q.thresh;
    assign plunger_pos = st_q.pos;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_bypass_refuse: assert property (
        fire && is_move && st_q.state == pump_pkg::S_IDLE && st_q.valve == pump_pkg::PORT_BYPASS
        |=> err_strobe && err_code == 4'hB && st_q.state == pump_pkg::S_IDLE)
        else $error("plunger move in bypass not refused");
    a_abs_range: assert property (
        fire && cmd.op == pump_pkg::OP_ABS && st_q.state == pump_pkg::S_IDLE
        && st_q.valve != pump_pkg::PORT_BYPASS && cmd.arg > 16'hBB8
        |=> err_strobe && err_code == 4'h3 && $stable(plunger_pos))
        else $error("absolute target out of range not refused");
    a_pickup_range: assert property (
        fire && cmd.op == pump_pkg::OP_PICKUP && st_q.state == pump_pkg::S_IDLE
        && st_q.valve != pump_pkg::PORT_BYPASS && 17'(cmd.arg) + 17'(plunger_pos) > 17'hBB8
        |=> err_strobe && err_code == 4'h3)
        else $error("pickup past top of range not refused");
    a_dispense_range: assert property (
        fire && cmd.op == pump_pkg::OP_DISPENSE && st_q.state == pump_pkg::S_IDLE
        && st_q.valve != pump_pkg::PORT_BYPASS && cmd.arg > 16'(plunger_pos)
        |=> err_strobe && err_code == 4'h3)
        else $error("dispense below zero not refused");
    a_novalve_ignore: assert property (
        fire && is_valve && !valve_fitted && st_q.state == pump_pkg::S_IDLE
        |=> !valve_go && $stable(valve_target) && !err_strobe)
        else $error("valve command acted on valveless unit");
    a_home_zero: assert property (
        st_q.state == pump_pkg::S_HOME && home_hit |=> plunger_pos == 12'h0 && !busy)
        else $error("homing did not end at zero");
    a_quiet_status: assert property (
        st_q.state == pump_pkg::S_RUN && st_q.quiet |-> !busy && cmd_ready)
        else $error("quiet move reported busy");
    a_otf_restore: assert property (
        st_q.otf && st_q.state == pump_pkg::S_RUN && st_d.state == pump_pkg::S_IDLE
        |=> st_q.top == $past(st_q.saved) && !st_q.otf)
        else $error("velocity not restored after speed change");
    a_leak_off: assert property (
        st_q.thresh == 8'h0 |-> !leak_alarm)
        else $error("leak reported with detection disabled");
endmodule : syringe_plunger_valve_sequencer
`default_nettype wire

/* File: test/pump_mech_model.sv */
// Mechanical stand-in for the home flag, encoder and valve drive
`timescale 1ns/1ps
`default_nettype none
module pump_mech_model #(
    parameter int VALVE_DLY = 5
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic step_pulse,
    input wire logic step_down,
    input wire logic valve_go,
    output logic home_hit,
    output logic valve_done,
    output logic [11:0] encoder_pos
);
    logic [11:0] mpos_q;
    int vcnt_q;
    // Flag follows the carriage, which starts at zero, so homing from there ends at once and keeps runs short
    assign home_hit = (mpos_q == 12'h000);
    assign encoder_pos = mpos_q;
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mpos_q <= 12'h000;
            vcnt_q <= 0;
            valve_done <= 1'b0;
        end
        else
        begin
            if (step_pulse && step_down)
                mpos_q <= mpos_q + 12'h001;
            else if (step_pulse && !home_hit)
                mpos_q <= mpos_q - 12'h001;
            valve_done <= (vcnt_q == 1);
            if (valve_go)
                vcnt_q <= VALVE_DLY;
            else if (vcnt_q != 0)
                vcnt_q <= vcnt_q - 1;
        end
    end
endmodule : pump_mech_model
`default_nettype wire

/* File: test/syringe_plunger_valve_sequencer_test.sv */
// Self-checking bench for the plunger and valve sequencer
`timescale 1ns/1ps
`default_nettype none
module syringe_plunger_valve_sequencer_test;
    typedef struct packed {
        pump_pkg::op_t op;
        logic [15:0] arg;
        logic [3:0] err;
        pump_pkg::port_t v;
    } row_t;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    pump_pkg::cmd_t cmd = '0;
    logic valve_fitted = 1'b1;
    logic [7:0] fluid_level = 8'h64;
    logic cmd_ready, busy, err_strobe, step_pulse, step_down, microstep, half_force;
    logic home_hit, valve_done, valve_go, leak_alarm;
    logic [11:0] encoder_pos, plunger_pos;
    logic [3:0] err_code;
    pump_pkg::port_t valve_target;
    int err_count = 0;
    int samples_checked = 0;
    int dn_steps = 0;
    int up_steps = 0;
    row_t rows [21];
    syringe_plunger_valve_sequencer #(.TICK_CYC(16)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .valve_fitted(valve_fitted),
        .distrib_valve(1'b1), .home_hit(home_hit), .valve_done(valve_done),
        .encoder_pos(encoder_pos), .fluid_level(fluid_level), .busy(busy),
        .err_strobe(err_strobe), .err_code(err_code), .step_pulse(step_pulse),
        .step_down(step_down), .microstep(microstep), .half_force(half_force),
        .valve_target(valve_target), .valve_go(valve_go), .leak_alarm(leak_alarm),
        .plunger_pos(plunger_pos));
    pump_mech_model u_mech (.ref_clk(ref_clk), .rst_n(rst_n), .step_pulse(step_pulse),
        .step_down(step_down), .valve_go(valve_go), .home_hit(home_hit),
        .valve_done(valve_done), .encoder_pos(encoder_pos));
    initial
    begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        if (step_pulse === 1'b1 && step_down === 1'b1)
            dn_steps++;
        else if (step_pulse === 1'b1)
            up_steps++;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up
    task automatic give_up;
        err_count++;
        $display("wrong value at %0t: wait ran out", $time);
        wrap_up();
    endtask : give_up
    // Lets one edge pass first, so back-to-back calls never raise valid in the step that dropped it
    task automatic send(input pump_pkg::op_t op, input logic q, input logic [15:0] a);
        int n;
        n = 0;
        @(posedge ref_clk);
        #2;
        cmd_valid = 1'b1;
        cmd = '{op: op, quiet: q, arg: a};
        while (cmd_ready !== 1'b1)
        begin
            @(posedge ref_clk);
            #2;
            n++;
            if (n > 200000)
                give_up();
        end
        @(posedge ref_clk);
        #2;
        cmd_valid = 1'b0;
    endtask : send
    task automatic wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0)
        begin
            @(posedge ref_clk);
            #2;
            n++;
            if (n > 100000)
                give_up();
        end
        // One more edge so the step counters have seen the final pulse
        @(posedge ref_clk);
        #2;
    endtask : wait_idle
    task automatic wait_pos(input logic [11:0] p);
        int n;
        n = 0;
        while (plunger_pos !== p)
        begin
            @(posedge ref_clk);
            #2;
            n++;
            if (n > 60000)
                give_up();
        end
        @(posedge ref_clk);
        #2;
    endtask : wait_pos
    initial
    begin
        rows = '{'{pump_pkg::OP_INIT_RIGHT, 16'h0000, 4'h0, pump_pkg::PORT_NONE},
            '{pump_pkg::OP_INIT_NOVALVE, 16'h0001, 4'h0, pump_pkg::PORT_NONE},
            '{pump_pkg::OP_VALVE_OUT, 16'h0000, 4'h0, pump_pkg::PORT_RIGHT},
            '{pump_pkg::OP_VALVE_IN, 16'h0000, 4'h0, pump_pkg::PORT_LEFT},
            '{pump_pkg::OP_VALVE_EXTRA, 16'h0000, 4'h0, pump_pkg::PORT_EXTRA},
            '{pump_pkg::OP_ABS, 16'h0BB9, 4'h3, pump_pkg::PORT_NONE},
            '{pump_pkg::OP_PICKUP, 16'h0BB9, 4'h3, pump_pkg::PORT_NONE},
            '{pump_pkg::OP_DISPENSE, 16'h0001, 4'h3, pump_pkg::PORT_NONE},
            '{pump_pkg::OP_INIT_RIGHT, 16'h0002, 4'h3, pump_pkg::PORT_NONE},
            '{pump_pkg::OP_VALVE_BYPASS, 16'h0000, 4'h0, pump_pkg::PORT_BYPASS},
            '{pump_pkg::OP_ABS, 16'h0000, 4'hB, pump_pkg::PORT_NONE},
            '{pump_pkg::OP_INIT_LEFT, 16'h0001, 4'h0, pump_pkg::PORT_NONE},
            '{pump_pkg::OP_VALVE_OUT, 16'h0000, 4'h0, pump_pkg::PORT_LEFT},
            '{pump_pkg::OP_VALVE_IN, 16'h0000, 4'h0, pump_pkg::PORT_RIGHT},
            '{pump_pkg::OP_PICKUP, 16'h0000, 4'h0, pump_pkg::PORT_NONE},
            '{pump_pkg::OP_DISPENSE, 16'h0000, 4'h0, pump_pkg::PORT_NONE},
            '{pump_pkg::OP_SET_START, 16'h03E8, 4'h0, pump_pkg::PORT_NONE},
            '{pump_pkg::OP_SET_TOP, 16'h16A8, 4'h0, pump_pkg::PORT_NONE},
            '{pump_pkg::OP_SET_CUTOFF, 16'h03E8, 4'h0, pump_pkg::PORT_NONE},
            '{pump_pkg::OP_SET_SLOPE, 16'h0014, 4'h0, pump_pkg::PORT_NONE},
            '{pump_pkg::OP_SET_TOP, 16'h16A9, 4'h3, pump_pkg::PORT_NONE}};
        repeat (3) @(posedge ref_clk);
        #2;
        rst_n = 1'b1;
        foreach (rows[i])
        begin
            send(rows[i].op, 1'b0, rows[i].arg);
            check(err_strobe, rows[i].err != 4'h0);
            if (rows[i].err != 4'h0)
                check(err_code, rows[i].err);
            if (rows[i].op inside {pump_pkg::OP_INIT_RIGHT, pump_pkg::OP_INIT_LEFT,
                pump_pkg::OP_INIT_NOVALVE} && rows[i].err == 4'h0)
                check(half_force, rows[i].arg[0]);
            if (rows[i].v != pump_pkg::PORT_NONE)
                check(valve_target, rows[i].v);
            wait_idle();
            if (rows[i].op inside {pump_pkg::OP_INIT_RIGHT, pump_pkg::OP_INIT_LEFT})
                check(plunger_pos, 12'h000);
        end
        $display("command table done");
        check(leak_alarm, 1'b0);
        send(pump_pkg::OP_SET_THRESH, 1'b0, 16'h0096);
        check(leak_alarm, 1'b1);
        fluid_level = 8'hC8;
        #1;
        check(leak_alarm, 1'b0);
        $display("leak test done");
        // Moves are kept to a step or two: at these rates each step costs thousands of cycles
        send(pump_pkg::OP_SET_BACKLASH, 1'b0, 16'h0001);
        send(pump_pkg::OP_PICKUP, 1'b0, 16'h0001);
        check(busy, 1'b1);
        check(step_down, 1'b1);
        wait_idle();
        check(dn_steps, 2);
        check(up_steps, 1);
        check(plunger_pos, 12'h001);
        send(pump_pkg::OP_RESYNC, 1'b0, 16'h0000);
        check(plunger_pos, 12'h001);
        $display("pickup with backlash done");
        // Start equals top, so the quiet move below may change speed
        send(pump_pkg::OP_SET_TOP, 1'b0, 16'h03E8);
        check(err_strobe, 1'b0);
        send(pump_pkg::OP_ABS, 1'b1, 16'h0000);
        check(busy, 1'b0);
        check(microstep, 1'b1);
        check(step_down, 1'b0);
        send(pump_pkg::OP_SET_TOP, 1'b0, 16'h0400);
        check(err_strobe, 1'b0);
        check(microstep, 1'b0);
        send(pump_pkg::OP_SET_TOP, 1'b0, 16'h07D0);
        check(err_strobe, 1'b1);
        check(err_code, 4'h3);
        send(pump_pkg::OP_SET_THRESH, 1'b0, 16'h0000);
        check(err_strobe, 1'b1);
        check(err_code, 4'h7);
        wait_pos(12'h000);
        check(up_steps, 2);
        check(plunger_pos, 12'h000);
        check(busy, 1'b0);
        $display("quiet move with speed change done");
        valve_fitted = 1'b0;
        send(pump_pkg::OP_VALVE_OUT, 1'b0, 16'h0000);
        check(valve_go, 1'b0);
        check(valve_target, pump_pkg::PORT_RIGHT);
        check(busy, 1'b0);
        rst_n = 1'b0;
        #1;
        check(cmd_ready, 1'b1);
        check(busy, 1'b0);
        check(plunger_pos, 12'h000);
        check(valve_target, pump_pkg::PORT_NONE);
        $display("reset test done");
        wrap_up();
    end
endmodule : syringe_plunger_valve_sequencer_test
`default_nettype wire
